// ### src/ndabf_pkg.sv
package ndabf_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ     = 25_000_000;
  localparam int BAUD_RATE  = 9600;
  localparam int BAUD_DIV   = CLK_HZ / BAUD_RATE;
  localparam int FRAME_BITS = 10;

  // ==========================================================
  // Control and filler characters
  localparam logic [7:0] CH_STX   = 8'h02;
  localparam logic [7:0] CH_ETX   = 8'h03;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_DASH  = 8'h2d;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_N     = 8'h4e;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_W     = 8'h57;
  localparam logic [7:0] CH_R     = 8'h52;
  localparam logic [7:0] CH_L     = 8'h4c;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [3:0] DIGIT_HI = 4'h3;
  localparam logic [3:0] BCD_MAX  = 4'h9;

  // ==========================================================
  // Item designators
  localparam logic [7:0] DES_LAT  = 8'h41;
  localparam logic [7:0] DES_LON  = 8'h42;
  localparam logic [7:0] DES_TRK  = 8'h43;
  localparam logic [7:0] DES_GS   = 8'h44;
  localparam logic [7:0] DES_DWP  = 8'h45;
  localparam logic [7:0] DES_XTK  = 8'h47;
  localparam logic [7:0] DES_DTK  = 8'h49;
  localparam logic [7:0] DES_AWP  = 8'h4b;
  localparam logic [7:0] DES_BRG  = 8'h4c;
  localparam logic [7:0] DES_VAR  = 8'h51;
  localparam logic [7:0] DES_WRN  = 8'h54;
  localparam logic [7:0] DES_DDST = 8'h6c;
  localparam logic [7:0] DES_WPT  = 8'h57;

  // ==========================================================
  // Field widths and positions
  localparam logic [4:0] LEN_LAT  = 5'h09;
  localparam logic [4:0] LEN_LON  = 5'h0a;
  localparam logic [4:0] LEN_3    = 5'h03;
  localparam logic [4:0] LEN_4    = 5'h04;
  localparam logic [4:0] LEN_5    = 5'h05;
  localparam logic [4:0] LEN_DDST = 5'h06;
  localparam logic [4:0] LEN_WRN  = 5'h09;
  localparam logic [4:0] LEN_WPT  = 5'h11;
  localparam int         WRN_FLAG_POS = 3;
  localparam int         WPT_SEQ_POS  = 2;
  localparam int         WPT_TEXT_POS = 3;
  localparam int         WPT_TEXT_CH  = 14;
  localparam int         SEQ_LAST_BIT = 6;
  localparam int         SEQ_ACT_BIT  = 5;
  localparam int         WPT_MAX_DEF  = 25;
  localparam int         RADIAL_RECIP = 1800;
  localparam int         FULL_CIRCLE  = 3600;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_STX   = 3'b001,
    S_DESIG = 3'b010,
    S_DATA  = 3'b011,
    S_TERM  = 3'b100,
    S_ETX   = 3'b101
  } ndabf_state_type;

  typedef enum logic [3:0] {
    IT_LAT  = 4'b0000, IT_LON = 4'b0001, IT_TRK = 4'b0010,
    IT_GS   = 4'b0011, IT_DWP = 4'b0100, IT_XTK = 4'b0101,
    IT_DTK  = 4'b0110, IT_AWP = 4'b0111, IT_BRG = 4'b1000,
    IT_VAR  = 4'b1001, IT_WRN = 4'b1010, IT_DDST = 4'b1011,
    IT_WPT  = 4'b1100
  } ndabf_item_type;

  // Numbers arrive as packed BCD, most significant digit first
  typedef struct packed {
    logic        pos_flag;
    logic        nav_flag;
    logic        low_speed_condition;
    logic        manual_course_mode;
    logic        epe_high;
    logic        lat_south;
    logic [23:0] lat_bcd;
    logic        lon_west;
    logic [27:0] lon_bcd;
    logic [11:0] trk_bcd;
    logic [11:0] gs_bcd;
    logic [19:0] dwp_bcd;
    logic        xtk_left;
    logic [15:0] xtk_bcd;
    logic [15:0] dtk_bcd;
    logic [15:0] crs_bcd;
    logic [15:0] brg_bcd;
    logic [15:0] radial_bcd;
    logic        var_west;
    logic [11:0] var_bcd;
    logic [39:0] awp_id;
    logic [23:0] ddst_bcd;
  } ndabf_nav_type;

endpackage : ndabf_pkg

// ### src/ndabf_uart_tx.sv
`timescale 1ns/10ps
module ndabf_uart_tx
  import ndabf_pkg::*;
#(
  parameter int DIV = BAUD_DIV
)
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_byte,
  output logic            tx_busy,
  output logic            tx_line
);

  // ==========================================================
  // Bit timer and shifter
  logic [15:0] baud_reg, baud_next;
  logic [3:0]  bit_reg, bit_next;
  logic [9:0]  shf_reg, shf_next;
  logic        busy_reg, busy_next;
  logic        line_reg, line_next;

  always_comb
  begin
    baud_next = baud_reg;
    bit_next  = bit_reg;
    shf_next  = shf_reg;
    busy_next = busy_reg;
    line_next = line_reg;
    if (!busy_reg)
    begin
      line_next = 1'b1; // [RULE22]
      if (tx_start)
      begin
        // Stop, data LSB first, start bit leaves the line [RULE21]
        shf_next  = {1'b1, tx_byte, 1'b0};
        line_next = 1'b0; // [RULE22]
        busy_next = 1'b1;
        baud_next = '0;
        bit_next  = '0;
      end
    end
    else if (baud_reg == 16'(DIV - 1))
    begin
      baud_next = '0;
      if (bit_reg == 4'(FRAME_BITS - 1))
      begin
        busy_next = 1'b0;
        line_next = 1'b1;
      end
      else
      begin
        bit_next  = bit_reg + 4'h1;
        shf_next  = {1'b1, shf_reg[9:1]};
        line_next = shf_reg[1]; // [RULE21]
      end
    end
    else
      baud_next = baud_reg + 16'h0001;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      baud_reg <= '0;
      bit_reg  <= '0;
      shf_reg  <= '1;
      busy_reg <= 1'b0;
      line_reg <= 1'b1;
    end
    else
    begin
      baud_reg <= baud_next;
      bit_reg  <= bit_next;
      shf_reg  <= shf_next;
      busy_reg <= busy_next;
      line_reg <= line_next;
    end
  end

  assign tx_busy = busy_reg;
  assign tx_line = line_reg;

  // ==========================================================
  // Checks
  logic [19:0] len_cnt;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      len_cnt <= '0;
    else
      len_cnt <= busy_reg ? len_cnt + 20'h00001 : '0;
  end

  AST_IDLE_MARK: assert property (@(posedge clk) disable iff (!nrst) // [RULE22]
    !busy_reg && !$past(tx_start) |-> line_reg)
    else $error("line not at mark while idle");
  AST_START_SPACE: assert property (@(posedge clk) disable iff (!nrst) // [RULE22]
    $rose(busy_reg) |-> !line_reg ##1 !line_reg)
    else $error("start bit not space");
  AST_FRAME_LEN: assert property (@(posedge clk) disable iff (!nrst) // [RULE21]
    $fell(busy_reg) |-> $past(len_cnt) == 20'(FRAME_BITS * DIV - 1))
    else $error("character frame length wrong");

endmodule : ndabf_uart_tx

// ### src/ndabf_framer.sv
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: Every block opens with start-of-text.
// RULE2: Item is designator, data, then terminator.
// RULE3: Item terminator is carriage return.
// RULE4: Every block closes with end-of-text.
// RULE5: Invalid or unrepresentable data becomes dashes.
// RULE6: Configuration selects one of two item sets.
// RULE7: Latitude: hemisphere, degrees, minutes, hundredths, nine chars.
// RULE8: Longitude: E/W, three degree digits, ten chars.
// RULE9: Track three digits, dashed on low speed.
// RULE10: Groundspeed three digits, dashed on position flag.
// RULE11: Waypoint distance five digits, nav flag dashes.
// RULE12: Crosstrack R/L plus four digits, nav dashes.
// RULE13: Desired track four digits, manual course substitutes.
// RULE14: Bearing four digits, manual uses radial plus 180.
// RULE15: Variation E/W plus three digits, position dashes.
// RULE16: Warnings fourth char A on high error.
// RULE17: Destination distance six digits, nav flag dashes.
// RULE18: Development test item is optional, not relied upon.
// RULE19: One waypoint item per flight plan waypoint.
// RULE20: Waypoint number, sequence byte, then identifier text.
// RULE21: Bytes go 9600 baud, 8N1, LSB first.
// RULE22: Line idles mark; start bit is space.
// RULE23: Dash filling keeps the full field width.
// RULE24: Designator is one case-sensitive ASCII character.
module ndabf_framer
  import ndabf_pkg::*;
#(
  parameter int WPT_MAX = WPT_MAX_DEF,
  parameter int DIV     = BAUD_DIV
)
(
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     block_start,
  input  wire logic                     output_set_select_page,
  input  wire ndabf_nav_type            nav_in,
  input  wire logic [4:0]               wpt_count,
  input  wire logic [4:0]               wpt_active,
  input  wire logic                     wpt_wr_en,
  input  wire logic [4:0]               wpt_wr_idx,
  input  wire logic [8*WPT_TEXT_CH-1:0] wpt_wr_data,
  output logic                          serial_out,
  output logic                          block_busy
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] dchar(input logic [3:0] d);
    return {DIGIT_HI, d};
  endfunction : dchar

  function automatic logic bcd_bad(input logic [27:0] v);
    logic b;
    b = 1'b0;
    for (int i = 0; i < 7; i++)
      if (v[4*i +: 4] > BCD_MAX)
        b = 1'b1;
    return b;
  endfunction : bcd_bad

  // Reciprocal of a radial in tenths of a degree
  function automatic logic [15:0] recip(input logic [15:0] r);
    int v;
    v = int'(r[15:12]) * 1000 + int'(r[11:8]) * 100
      + int'(r[7:4]) * 10 + int'(r[3:0]);
    v = (v + RADIAL_RECIP) % FULL_CIRCLE;
    return {4'(v / 1000), 4'((v / 100) % 10), 4'((v / 10) % 10),
            4'(v % 10)};
  endfunction : recip

  // ==========================================================
  // Flight plan store
  logic [8*WPT_TEXT_CH-1:0] wpt_mem [0:WPT_MAX-1];

  always_ff @(posedge clk)
  begin
    if (wpt_wr_en && int'(wpt_wr_idx) < WPT_MAX)
      wpt_mem[wpt_wr_idx] <= wpt_wr_data;
  end

  // ==========================================================
  // Sequencer state
  ndabf_state_type state_reg, state_next;
  ndabf_item_type  item_reg, item_next;
  logic [4:0]      pos_reg, pos_next;
  logic [4:0]      wpt_reg, wpt_next;
  logic [4:0]      cnt_reg, cnt_next;
  logic [4:0]      act_reg, act_next;
  logic            set_reg, set_next;
  ndabf_nav_type   nav_reg, nav_next;
  logic            busy_reg, busy_next;
  logic            tx_start_reg, tx_start_next;
  logic [7:0]      tx_byte_reg, tx_byte_next;
  logic            uart_busy;

  // ==========================================================
  // Current item image
  logic [7:0] fld_c [0:16];
  logic [7:0] desig_c;
  logic [4:0] len_c;
  logic       bad_c;
  logic [7:0] char_c;
  logic       issue;
  logic [7:0] wpt_num;
  logic [15:0] dtk_src;
  logic [15:0] brg_src;

  always_comb
  begin
    for (int i = 0; i < 17; i++)
      fld_c[i] = CH_DASH;
    desig_c = DES_LAT;
    len_c   = LEN_LAT;
    bad_c   = 1'b0;
    wpt_num = {4'(({3'b000, wpt_reg} + 8'h01) / 8'h0a),
               4'(({3'b000, wpt_reg} + 8'h01) % 8'h0a)};
    dtk_src = nav_reg.manual_course_mode ? nav_reg.crs_bcd
                                         : nav_reg.dtk_bcd; // [RULE13]
    brg_src = nav_reg.manual_course_mode ? recip(nav_reg.radial_bcd)
                                         : nav_reg.brg_bcd; // [RULE14]
    case (item_reg)
      IT_LAT:
      begin
        desig_c  = DES_LAT;
        len_c    = LEN_LAT;
        bad_c    = nav_reg.pos_flag || bcd_bad(28'(nav_reg.lat_bcd));
        fld_c[0] = nav_reg.lat_south ? CH_S : CH_N; // [RULE7]
        fld_c[1] = CH_SPACE;
        fld_c[2] = dchar(nav_reg.lat_bcd[23:20]);
        fld_c[3] = dchar(nav_reg.lat_bcd[19:16]);
        fld_c[4] = CH_SPACE;
        for (int i = 0; i < 4; i++)
          fld_c[5+i] = dchar(nav_reg.lat_bcd[15-4*i -: 4]);
      end
      IT_LON:
      begin
        desig_c  = DES_LON;
        len_c    = LEN_LON;
        bad_c    = nav_reg.pos_flag || bcd_bad(nav_reg.lon_bcd);
        fld_c[0] = nav_reg.lon_west ? CH_W : CH_E; // [RULE8]
        fld_c[1] = CH_SPACE;
        for (int i = 0; i < 3; i++)
          fld_c[2+i] = dchar(nav_reg.lon_bcd[27-4*i -: 4]);
        fld_c[5] = CH_SPACE;
        for (int i = 0; i < 4; i++)
          fld_c[6+i] = dchar(nav_reg.lon_bcd[15-4*i -: 4]);
      end
      IT_TRK:
      begin
        desig_c = DES_TRK;
        len_c   = LEN_3;
        // The enhanced set also dashes on a position flag
        bad_c   = nav_reg.low_speed_condition
                  || (set_reg && nav_reg.pos_flag)
                  || bcd_bad(28'(nav_reg.trk_bcd)); // [RULE9] [RULE6]
        for (int i = 0; i < 3; i++)
          fld_c[i] = dchar(nav_reg.trk_bcd[11-4*i -: 4]);
      end
      IT_GS:
      begin
        desig_c = DES_GS;
        len_c   = LEN_3;
        bad_c   = nav_reg.pos_flag || bcd_bad(28'(nav_reg.gs_bcd)); // [RULE10]
        for (int i = 0; i < 3; i++)
          fld_c[i] = dchar(nav_reg.gs_bcd[11-4*i -: 4]);
      end
      IT_DWP:
      begin
        desig_c = DES_DWP;
        len_c   = LEN_5;
        bad_c   = nav_reg.nav_flag || bcd_bad(28'(nav_reg.dwp_bcd)); // [RULE11]
        for (int i = 0; i < 5; i++)
          fld_c[i] = dchar(nav_reg.dwp_bcd[19-4*i -: 4]);
      end
      IT_XTK:
      begin
        desig_c  = DES_XTK;
        len_c    = LEN_5;
        bad_c    = nav_reg.nav_flag || bcd_bad(28'(nav_reg.xtk_bcd));
        fld_c[0] = nav_reg.xtk_left ? CH_L : CH_R; // [RULE12]
        for (int i = 0; i < 4; i++)
          fld_c[1+i] = dchar(nav_reg.xtk_bcd[15-4*i -: 4]);
      end
      IT_DTK:
      begin
        desig_c = DES_DTK;
        len_c   = LEN_4;
        bad_c   = nav_reg.nav_flag || bcd_bad(28'(dtk_src)); // [RULE13]
        for (int i = 0; i < 4; i++)
          fld_c[i] = dchar(dtk_src[15-4*i -: 4]);
      end
      IT_AWP:
      begin
        desig_c = DES_AWP;
        len_c   = LEN_5;
        for (int i = 0; i < 5; i++)
          fld_c[i] = nav_reg.awp_id[39-8*i -: 8];
      end
      IT_BRG:
      begin
        desig_c = DES_BRG;
        len_c   = LEN_4;
        bad_c   = nav_reg.pos_flag || bcd_bad(28'(brg_src)); // [RULE14]
        for (int i = 0; i < 4; i++)
          fld_c[i] = dchar(brg_src[15-4*i -: 4]);
      end
      IT_VAR:
      begin
        desig_c  = DES_VAR;
        len_c    = LEN_4;
        bad_c    = nav_reg.pos_flag || bcd_bad(28'(nav_reg.var_bcd));
        fld_c[0] = nav_reg.var_west ? CH_W : CH_E; // [RULE15]
        for (int i = 0; i < 3; i++)
          fld_c[1+i] = dchar(nav_reg.var_bcd[11-4*i -: 4]);
      end
      IT_WRN:
      begin
        desig_c = DES_WRN;
        len_c   = LEN_WRN;
        fld_c[WRN_FLAG_POS] = nav_reg.epe_high ? CH_A : CH_DASH; // [RULE16]
      end
      IT_DDST:
      begin
        desig_c = DES_DDST; // [RULE24]
        len_c   = LEN_DDST;
        bad_c   = nav_reg.nav_flag || bcd_bad(28'(nav_reg.ddst_bcd)); // [RULE17]
        for (int i = 0; i < 6; i++)
          fld_c[i] = dchar(nav_reg.ddst_bcd[23-4*i -: 4]);
      end
      default:
      begin
        desig_c  = DES_WPT;
        len_c    = LEN_WPT;
        fld_c[0] = dchar(wpt_num[7:4]); // [RULE20]
        fld_c[1] = dchar(wpt_num[3:0]);
        fld_c[WPT_SEQ_POS] = {1'b0, wpt_reg == 5'(cnt_reg - 5'h01),
                              wpt_reg == act_reg, wpt_reg}; // [RULE20]
        for (int i = 0; i < WPT_TEXT_CH; i++)
          fld_c[WPT_TEXT_POS+i] =
            wpt_mem[wpt_reg][8*(WPT_TEXT_CH-1-i) +: 8];
      end
    endcase
    // Every character of the field goes, width kept
    if (bad_c)
      for (int i = 0; i < 17; i++)
        fld_c[i] = CH_DASH; // [RULE5] [RULE23]
    case (state_reg)
      S_STX:   char_c = CH_STX;       // [RULE1]
      S_DESIG: char_c = desig_c;      // [RULE24]
      S_DATA:  char_c = fld_c[pos_reg];
      S_TERM:  char_c = CH_CR;        // [RULE3]
      default: char_c = CH_ETX;       // [RULE4]
    endcase
  end

  // One byte handed over per idle gap of the transmitter
  assign issue = state_reg != S_IDLE && !uart_busy && !tx_start_reg;

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_next    = state_reg;
    item_next     = item_reg;
    pos_next      = pos_reg;
    wpt_next      = wpt_reg;
    cnt_next      = cnt_reg;
    act_next      = act_reg;
    set_next      = set_reg;
    nav_next      = nav_reg;
    tx_start_next = issue;
    tx_byte_next  = issue ? char_c : tx_byte_reg;
    if (state_reg == S_IDLE)
    begin
      if (block_start)
      begin
        // Snapshot keeps one block self-consistent
        state_next = S_STX; // [RULE1]
        set_next   = output_set_select_page; // [RULE6]
        nav_next   = nav_in;
        cnt_next   = int'(wpt_count) > WPT_MAX ? 5'(WPT_MAX) : wpt_count;
        act_next   = wpt_active;
        item_next  = IT_LAT;
        wpt_next   = '0;
      end
    end
    else if (issue)
    begin
      case (state_reg)
        S_STX:   state_next = S_DESIG;
        S_DESIG:
        begin
          state_next = S_DATA; // [RULE2]
          pos_next   = '0;
        end
        S_DATA:
          if (pos_reg == 5'(len_c - 5'h01))
            state_next = S_TERM; // [RULE2]
          else
            pos_next = pos_reg + 5'h01;
        S_TERM:
        begin
          state_next = S_DESIG;
          // Development test item is never emitted [RULE18]
          if (item_reg == IT_WPT && wpt_reg != 5'(cnt_reg - 5'h01))
            wpt_next = wpt_reg + 5'h01; // [RULE19]
          else if (item_reg == IT_WPT
                   || (item_reg == IT_WRN && set_reg) // [RULE6]
                   || (item_reg == IT_DDST && cnt_reg == '0))
            state_next = S_ETX; // [RULE4]
          else
            item_next = ndabf_item_type'(item_reg + 4'h1);
        end
        default: state_next = S_IDLE;
      endcase
    end
    busy_next = state_next != S_IDLE;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= S_IDLE;
      item_reg     <= IT_LAT;
      pos_reg      <= '0;
      wpt_reg      <= '0;
      cnt_reg      <= '0;
      act_reg      <= '0;
      set_reg      <= 1'b0;
      nav_reg      <= '0;
      busy_reg     <= 1'b0;
      tx_start_reg <= 1'b0;
      tx_byte_reg  <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      item_reg     <= item_next;
      pos_reg      <= pos_next;
      wpt_reg      <= wpt_next;
      cnt_reg      <= cnt_next;
      act_reg      <= act_next;
      set_reg      <= set_next;
      nav_reg      <= nav_next;
      busy_reg     <= busy_next;
      tx_start_reg <= tx_start_next;
      tx_byte_reg  <= tx_byte_next;
    end
  end

  assign block_busy = busy_reg;

  // ==========================================================
  // Serialiser
  ndabf_uart_tx #(.DIV(DIV)) u_tx (
    .clk      (clk),
    .nrst     (nrst),
    .tx_start (tx_start_reg),
    .tx_byte  (tx_byte_reg),
    .tx_busy  (uart_busy),
    .tx_line  (serial_out)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Data characters handed over in the current item
  logic [4:0] dcnt;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dcnt <= '0;
    else if (issue)
      dcnt <= state_reg == S_DATA ? dcnt + 5'h01 : '0;
  end

  sequence s_sent(ndabf_state_type st, logic c);
    issue && state_reg == st && c;
  endsequence

  AST_STX_FIRST: assert property ( // [RULE1]
    s_sent(S_STX, 1'b1) |=> tx_start_reg && tx_byte_reg == CH_STX
                      && state_reg == S_DESIG && item_reg == IT_LAT)
    else $error("block not opened by start-of-text");
  AST_DESIG_DATA: assert property ( // [RULE2]
    s_sent(S_DESIG, 1'b1) |=> state_reg == S_DATA && pos_reg == '0)
    else $error("designator not followed by data");
  AST_CR_TERM: assert property ( // [RULE3]
    s_sent(S_TERM, 1'b1) |=> tx_byte_reg == CH_CR)
    else $error("item terminator not carriage return");
  AST_ETX_LAST: assert property ( // [RULE4]
    s_sent(S_ETX, 1'b1) |=> tx_byte_reg == CH_ETX && state_reg == S_IDLE)
    else $error("block not closed by end-of-text");
  AST_DASH_FILL: assert property ( // [RULE5]
    s_sent(S_DATA, bad_c) |=> tx_byte_reg == CH_DASH)
    else $error("invalid item not dashed");
  AST_TRK_LOW: assert property ( // [RULE9]
    s_sent(S_DATA, item_reg == IT_TRK && nav_reg.low_speed_condition)
    |=> tx_byte_reg == CH_DASH)
    else $error("track not dashed at low speed");
  AST_ENH_END: assert property ( // [RULE6]
    s_sent(S_TERM, set_reg && item_reg == IT_WRN)
    |=> state_reg == S_ETX)
    else $error("enhanced set did not end after warnings");
  AST_WPT_LAST: assert property ( // [RULE20]
    s_sent(S_DATA, item_reg == IT_WPT && pos_reg == 5'(WPT_SEQ_POS)
    && wpt_reg == 5'(cnt_reg - 5'h01)) |=> tx_byte_reg[SEQ_LAST_BIT])
    else $error("last waypoint bit missing");
  AST_DATA_WIDTH: assert property ( // [RULE23]
    s_sent(S_TERM, 1'b1) |-> dcnt == len_c)
    else $error("field width not kept");

endmodule : ndabf_framer

// ### verification/ndabf_listener.sv
`timescale 1ns/10ps
// ==================================================
// Far-side listener decoding the serial output line
module ndabf_listener
#(
  parameter int DIV = 8
)
(
  input  wire logic  clk,
  input  wire logic  line,
  output logic [7:0] rx_byte,
  output logic       rx_valid,
  output logic       rx_bad
);
  initial
  begin
    rx_byte  = 8'h00;
    rx_valid = 1'b0;
    rx_bad   = 1'b0;
  end

  // Mid-bit sampling, so edge races on the line cannot matter
  always
  begin
    @(negedge line);                  // Mark to space opens a frame
    repeat (DIV / 2) @(posedge clk);
    rx_bad <= line;                   // Start bit still space
    for (int k = 0; k < 8; k++)
    begin
      repeat (DIV) @(posedge clk);
      rx_byte[k] <= line;             // Eight bits, LSB first
    end
    repeat (DIV) @(posedge clk);
    rx_bad   <= rx_bad | !line;       // One stop bit at mark
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
  end
endmodule : ndabf_listener

// ### verification/ndabf_framer_test.sv
`timescale 1ns/10ps
module ndabf_framer_test;
  import ndabf_pkg::*;
  // Short bit time keeps the run small
  localparam int D = 8;
  logic                     clk = 1'b0;
  logic                     nrst = 1'b0;
  logic                     start = 1'b0;
  logic                     sel = 1'b0;
  ndabf_nav_type            nav = '0;
  logic [4:0]               cnt = 5'h00;
  logic [4:0]               act = 5'h00;
  logic                     wr_en = 1'b0;
  logic [4:0]               wr_idx = 5'h00;
  logic [8*WPT_TEXT_CH-1:0] wr_data = '0;
  logic [8*WPT_TEXT_CH-1:0] store [3];
  logic                     ser, busy, rx_valid, rx_bad;
  logic [7:0]               rx_byte;
  logic [7:0]               expq [$];
  int                       bad_count = 0;
  int                       check_count = 0;

  always #20 clk = ~clk;

  ndabf_framer #(.DIV(D)) ndabf_framer_i (.clk(clk), .nrst(nrst),
    .block_start(start), .output_set_select_page(sel), .nav_in(nav),
    .wpt_count(cnt), .wpt_active(act), .wpt_wr_en(wr_en),
    .wpt_wr_idx(wr_idx), .wpt_wr_data(wr_data), .serial_out(ser),
    .block_busy(busy));
  ndabf_listener #(.DIV(D)) ndabf_listener_i (.clk(clk), .line(ser),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_bad(rx_bad));

  // ==================================================
  // Expected stream
  task automatic fail(input string m);
    bad_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail

  // Lower-case hex digit means a nibble above nine
  task automatic item(input logic [7:0] d, input string s, input logic dsh);
    expq.push_back(d);
    foreach (s[k]) if (s[k] inside {["a":"f"]}) dsh = 1'b1;
    foreach (s[k]) expq.push_back(dsh ? CH_DASH : 8'(s[k]));
    expq.push_back(CH_CR);
  endtask : item

  task automatic expect_block(input ndabf_nav_type v, input logic en,
                              input int n);
    logic  p;
    logic  f;
    string s;
    int    r;
    p = v.pos_flag;
    f = v.nav_flag;
    s = $sformatf("%h", v.radial_bcd);
    r = (s.atoi() + RADIAL_RECIP) % FULL_CIRCLE;
    expq.push_back(CH_STX);
    item(DES_LAT, $sformatf("%s %h %h", v.lat_south ? "S" : "N",
      v.lat_bcd[23:16], v.lat_bcd[15:0]), p);
    item(DES_LON, $sformatf("%s %h %h", v.lon_west ? "W" : "E",
      v.lon_bcd[27:16], v.lon_bcd[15:0]), p);
    item(DES_TRK, $sformatf("%h", v.trk_bcd),
      v.low_speed_condition | (en & p));
    item(DES_GS, $sformatf("%h", v.gs_bcd), p);
    item(DES_DWP, $sformatf("%h", v.dwp_bcd), f);
    item(DES_XTK, $sformatf("%s%h", v.xtk_left ? "L" : "R", v.xtk_bcd),
      f);
    item(DES_DTK, $sformatf("%h", v.manual_course_mode ? v.crs_bcd :
      v.dtk_bcd), f);
    item(DES_AWP, $sformatf("%s", v.awp_id), 1'b0);
    item(DES_BRG, v.manual_course_mode ? $sformatf("%04d", r) :
      $sformatf("%h", v.brg_bcd), p);
    item(DES_VAR, $sformatf("%s%h", v.var_west ? "W" : "E", v.var_bcd),
      p);
    item(DES_WRN, v.epe_high ? "---A-----" : "---------", 1'b0);
    if (!en)
    begin
      item(DES_DDST, $sformatf("%h", v.ddst_bcd), f);
      for (int i = 0; i < n; i++)
      begin
        expq.push_back(DES_WPT);
        expq.push_back({DIGIT_HI, 4'((i + 1) / 10)});
        expq.push_back({DIGIT_HI, 4'((i + 1) % 10)});
        expq.push_back({1'b0, i == n - 1, i == 1, 5'(i)});
        for (int k = WPT_TEXT_CH - 1; k >= 0; k--)
          expq.push_back(store[i][8*k+:8]);
        expq.push_back(CH_CR);
      end
    end
    expq.push_back(CH_ETX);
  endtask : expect_block

  function automatic logic [27:0] rd();
    for (int k = 0; k < 7; k++) rd[4*k+:4] = 4'($urandom_range(9));
  endfunction : rd

  task automatic run_block(input int k);
    ndabf_nav_type v;
    v = '0;
    v.lat_bcd = 24'(rd());
    v.lon_bcd = rd();
    v.trk_bcd = 12'(rd());
    v.gs_bcd = 12'(rd());
    v.dwp_bcd = 20'(rd());
    v.xtk_bcd = 16'(rd());
    v.dtk_bcd = 16'(rd());
    v.crs_bcd = 16'(rd());
    v.brg_bcd = 16'(rd());
    v.radial_bcd = {4'($urandom_range(2)), 12'(rd())};
    v.var_bcd = 12'(rd());
    v.ddst_bcd = 24'(rd());
    {v.lat_south, v.lon_west, v.xtk_left, v.var_west} = 4'($urandom);
    for (int j = 0; j < 5; j++) v.awp_id[8*j+:8] = 8'($urandom_range(25)) + CH_A;
    v.pos_flag = k[1];
    v.nav_flag = k[1];
    v.low_speed_condition = (k == 1);
    v.manual_course_mode = (k == 1);
    v.epe_high = k[0];
    if (k == 1) v.gs_bcd[3:0] = 4'hc;
    expect_block(v, k == 2, 3 - k);
    @(posedge clk);
    nav <= v;
    sel <= (k == 2);
    cnt <= 5'(3 - k);
    act <= 5'h01;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    // Request and new data while busy must change nothing
    repeat (5) @(posedge clk);
    start <= 1'b1;
    nav <= '0;
    @(posedge clk);
    start <= 1'b0;
    for (int w = 0; w < 20000 && expq.size() > 0; w++) @(posedge clk);
    if (expq.size() > 0) fail("block timed out");
  endtask : run_block

  // ==================================================
  // Monitor and closing
  always @(posedge clk)
    if (rx_valid)
    begin
      check_count++;
      if (expq.size() == 0) fail("unexpected byte");
      else if (rx_byte !== expq.pop_front()) fail("byte differs");
      if (rx_bad !== 1'b0) fail("framing");
    end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (90000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(53611));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    check_count++;
    if (ser !== 1'b1) fail("line not idle");
    for (int i = 0; i < 3; i++)
    begin
      for (int c = 0; c < WPT_TEXT_CH; c++)
        store[i][8*c+:8] = 8'($urandom_range(25)) + CH_A;
      @(posedge clk);
      wr_en <= 1'b1;
      wr_idx <= 5'(i);
      wr_data <= store[i];
    end
    @(posedge clk);
    wr_en <= 1'b0;
    for (int k = 0; k < 4; k++) run_block(k);
    repeat (20 * D) @(posedge clk);
    check_count++;
    if (expq.size() != 0 || busy !== 1'b0) fail("block incomplete");
    tally_and_finish();
  end
endmodule : ndabf_framer_test
